// ### rfid_write_cmd.sv
module rfid_write_cmd #(
  parameter int timeout_cyc = rfid_pkg::tag_timeout_cyc
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  output logic tag_req,
  output logic tag_op_write,
  output logic [7:0] tag_block,
  output logic tag_key_b,
  output logic [47:0] tag_key,
  output logic [127:0] tag_data,
  input wire logic tag_ack,
  input wire logic tag_ok
);
  tag_op_if op ();
  rfid_pkg::cmd_state_e st_r;
  logic [7:0] arg_r [rfid_pkg::arg_bytes];
  logic [7:0] buf_r [rfid_pkg::buf_bytes];
  logic [47:0] key_mem [rfid_pkg::key_count];
  logic [7:0] awaddr_r;
  logic aw_got_r, w_got_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic [7:0] cmd_r, result_r;
  logic [1:0] irq_st_r, irq_mask_r;
  logic [47:0] key_stage_r;
  logic [47:0] key_r;
  logic key_b_r;
  logic [7:0] blk_r, cnt_r;
  logic [5:0] off_r;
  logic start_r, op_write_r;
  logic fin_r, fin_err_r;
  logic busy;
  logic [5:0] idx_sel;
  logic [47:0] inline_key;
  logic [127:0] gather;
  logic [7:0] blk_nxt;
  logic [31:0] rd_nxt;
  logic rd_err;

  // sector number of a block: small then big sectors
  function automatic logic [5:0] sector_of(input logic [7:0] b);
    logic [7:0] rel;
    rel = b - rfid_pkg::big_sector_start;
    if (b < rfid_pkg::big_sector_start)
      sector_of = b[7:2];
    else
      sector_of = rfid_pkg::big_sector_base + {2'b00, rel[7:4]};
  endfunction

  assign busy = (st_r != rfid_pkg::s_idle);
  assign blk_nxt = blk_r + 8'h01;
  assign idx_sel = arg_r[rfid_pkg::arg_keysel][5:0];
  // inline key bytes, lowest offset is least significant
  assign inline_key = {arg_r[rfid_pkg::arg_key + 5],
                       arg_r[rfid_pkg::arg_key + 4],
                       arg_r[rfid_pkg::arg_key + 3],
                       arg_r[rfid_pkg::arg_key + 2],
                       arg_r[rfid_pkg::arg_key + 1],
                       arg_r[rfid_pkg::arg_key]};

  // one block of buffer bytes starting at the running offset
  genvar gi;
  generate
    for (gi = 0; gi < rfid_pkg::block_bytes; gi++)
    begin : g_gather
      assign gather[gi*8 +: 8] = buf_r[off_r + 6'(gi)];
    end
  endgenerate

  // axi write: address and data taken in either order
  assign awready = !aw_got_r && !bvalid; // held low until response taken
  assign wready = !w_got_r && !bvalid;
  assign do_wr = aw_got_r && w_got_r && !bvalid;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= rfid_pkg::resp_okay;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_wr)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awaddr_r[1:0] != 2'b00 ||
                  (awaddr_r > rfid_pkg::adr_key_store &&
                   awaddr_r < rfid_pkg::adr_buf_base)) ?
                 rfid_pkg::resp_slverr : rfid_pkg::resp_okay;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // argument and buffer stores, frozen while a command runs
  always_ff @(posedge core_clk)
  begin
    if (do_wr && !busy)
    begin
      for (int l = 0; l < 4; l++)
      begin
        if (wstrb_r[l])
        begin
          if (awaddr_r >= rfid_pkg::adr_buf_base)
            buf_r[{awaddr_r[5:2], 2'(l)}] <= wdata_r[l*8 +: 8];
          else if (awaddr_r == rfid_pkg::adr_arg0)
            arg_r[l] <= wdata_r[l*8 +: 8];
          else if (awaddr_r == rfid_pkg::adr_arg1)
            arg_r[4 + l] <= wdata_r[l*8 +: 8];
          else if (awaddr_r == rfid_pkg::adr_arg2 && l < 2)
            arg_r[8 + l] <= wdata_r[l*8 +: 8];
        end
      end
    end
  end

  // stored key table, loaded through a staging pair
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      key_stage_r <= 48'h0;
    else if (do_wr && awaddr_r == rfid_pkg::adr_key_lo)
      key_stage_r[31:0] <= wdata_r;
    else if (do_wr && awaddr_r == rfid_pkg::adr_key_hi)
      key_stage_r[47:32] <= wdata_r[15:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (do_wr && awaddr_r == rfid_pkg::adr_key_store && !busy &&
        wdata_r[5:0] <= rfid_pkg::key_idx_max && wdata_r[31:6] == 26'h0)
      key_mem[wdata_r[5:0]] <= key_stage_r;
  end

  // command sequencer
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_r <= rfid_pkg::s_idle;
      cmd_r <= 8'h00;
      result_r <= rfid_pkg::res_rst;
      key_r <= 48'h0;
      key_b_r <= 1'b0;
      blk_r <= 8'h00;
      cnt_r <= 8'h00;
      off_r <= 6'h00;
      start_r <= 1'b0;
      op_write_r <= 1'b0;
      fin_r <= 1'b0;
      fin_err_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      fin_r <= 1'b0;
      case (st_r)
        rfid_pkg::s_idle:
          if (do_wr && awaddr_r == rfid_pkg::adr_command && wstrb_r[0])
          begin
            cmd_r <= wdata_r[7:0];
            fin_r <= 1'b1;
            fin_err_r <= 1'b1;
            if (wdata_r[7:0] != rfid_pkg::cmd_write_blocks)
              result_r <= rfid_pkg::res_bad_cmd;
            else if (!arg_r[rfid_pkg::arg_keysel][rfid_pkg::sel_inline_bit]
                     && idx_sel > rfid_pkg::key_idx_max)
              result_r <= rfid_pkg::res_key_err;
            else
            begin
              fin_r <= 1'b0;
              fin_err_r <= 1'b0;
              key_r <= arg_r[rfid_pkg::arg_keysel][rfid_pkg::sel_inline_bit]
                       ? inline_key : key_mem[idx_sel];
              key_b_r <= arg_r[rfid_pkg::arg_keysel]
                         [rfid_pkg::sel_key_b_bit];
              blk_r <= arg_r[rfid_pkg::arg_block];
              cnt_r <= arg_r[rfid_pkg::arg_count];
              off_r <= arg_r[rfid_pkg::arg_offset][5:0];
              st_r <= rfid_pkg::s_auth;
            end
          end
        rfid_pkg::s_auth:
        begin
          start_r <= 1'b1;
          op_write_r <= 1'b0;
          st_r <= rfid_pkg::s_auth_w;
        end
        rfid_pkg::s_auth_w:
          if (op.done)
          begin
            if (!op.ok)
            begin
              result_r <= rfid_pkg::res_auth_err;
              fin_r <= 1'b1;
              fin_err_r <= 1'b1;
              st_r <= rfid_pkg::s_idle;
            end
            else
              st_r <= rfid_pkg::s_write;
          end
        rfid_pkg::s_write:
        begin
          start_r <= 1'b1;
          op_write_r <= 1'b1;
          st_r <= rfid_pkg::s_write_w;
        end
        rfid_pkg::s_write_w:
          if (op.done)
          begin
            if (!op.ok)
            begin
              result_r <= rfid_pkg::res_write_err;
              fin_r <= 1'b1;
              fin_err_r <= 1'b1;
              st_r <= rfid_pkg::s_idle;
            end
            else if (cnt_r <= 8'h01)
            begin
              result_r <= rfid_pkg::res_no_error;
              fin_r <= 1'b1;
              fin_err_r <= 1'b0;
              st_r <= rfid_pkg::s_idle;
            end
            else
            begin
              cnt_r <= cnt_r - 8'h01;
              blk_r <= blk_nxt;
              off_r <= off_r + 6'(rfid_pkg::block_bytes);
              st_r <= (sector_of(blk_nxt) != sector_of(blk_r)) ?
                      rfid_pkg::s_auth : rfid_pkg::s_write;
            end
          end
        default:
          st_r <= rfid_pkg::s_idle;
      endcase
    end
  end

  // request toward the tag engine
  assign op.start = start_r;
  assign op.op_write = op_write_r;
  assign op.block = blk_r;
  assign op.key_b = key_b_r;
  assign op.key = key_r;
  assign op.data = gather;

  // sticky interrupt status, set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      irq_st_r <= 2'h0;
      irq_mask_r <= rfid_pkg::irq_mask_rst;
    end
    else
    begin
      if (do_wr && awaddr_r == rfid_pkg::adr_irq_mask)
        irq_mask_r <= wdata_r[1:0];
      irq_st_r <= (irq_st_r &
                   ~((do_wr && awaddr_r == rfid_pkg::adr_irq_status) ?
                     wdata_r[1:0] : 2'h0)) |
                  {fin_r && fin_err_r, fin_r};
    end
  end

  assign irq = |(irq_st_r & irq_mask_r);

  // read mux
  always_comb
  begin
    rd_nxt = 32'h0;
    rd_err = 1'b0;
    if (araddr >= rfid_pkg::adr_buf_base)
      rd_nxt = {buf_r[{araddr[5:2], 2'd3}], buf_r[{araddr[5:2], 2'd2}],
                buf_r[{araddr[5:2], 2'd1}], buf_r[{araddr[5:2], 2'd0}]};
    else
      case (araddr)
        rfid_pkg::adr_command: rd_nxt = {23'h0, busy, cmd_r};
        rfid_pkg::adr_result: rd_nxt = {24'h0, result_r};
        rfid_pkg::adr_arg0: rd_nxt = {arg_r[3], arg_r[2], arg_r[1], arg_r[0]};
        rfid_pkg::adr_arg1: rd_nxt = {arg_r[7], arg_r[6], arg_r[5], arg_r[4]};
        rfid_pkg::adr_arg2: rd_nxt = {16'h0, arg_r[9], arg_r[8]};
        rfid_pkg::adr_irq_status: rd_nxt = {30'h0, irq_st_r};
        rfid_pkg::adr_irq_mask: rd_nxt = {30'h0, irq_mask_r};
        rfid_pkg::adr_key_lo: rd_nxt = 32'h0;
        rfid_pkg::adr_key_hi: rd_nxt = 32'h0;
        rfid_pkg::adr_key_store: rd_nxt = 32'h0;
        default: rd_err = 1'b1;
      endcase
  end

  // axi read channel, one outstanding read
  assign arready = !rvalid;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= rfid_pkg::resp_okay;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rd_err ? 32'h0 : rd_nxt;
      rresp <= rd_err ? rfid_pkg::resp_slverr : rfid_pkg::resp_okay;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  tag_engine #(.timeout_cyc(timeout_cyc)) u_eng (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .op(op),
    .tag_req(tag_req),
    .tag_op_write(tag_op_write),
    .tag_block(tag_block),
    .tag_key_b(tag_key_b),
    .tag_key(tag_key),
    .tag_data(tag_data),
    .tag_ack(tag_ack),
    .tag_ok(tag_ok)
  );
endmodule

// ### rfid_pkg.sv
package rfid_pkg;
  // command codes and result codes
  localparam logic [7:0] cmd_write_blocks = 8'h03;
  localparam logic [7:0] res_no_error = 8'h00;
  localparam logic [7:0] res_auth_err = 8'h01;
  localparam logic [7:0] res_write_err = 8'h02;
  localparam logic [7:0] res_key_err = 8'h03;
  localparam logic [7:0] res_bad_cmd = 8'h04;
  localparam logic [7:0] res_rst = 8'h00;
  // argument byte positions
  localparam int arg_block = 0;
  localparam int arg_count = 1;
  localparam int arg_offset = 2;
  localparam int arg_keysel = 3;
  localparam int arg_key = 4;
  localparam int key_len = 6;
  localparam int arg_bytes = 10;
  // key selector fields
  localparam int sel_key_b_bit = 7;
  localparam int sel_inline_bit = 6;
  localparam logic [5:0] key_idx_max = 6'h27;
  localparam int key_count = 40;
  // tag memory geometry
  localparam int block_bytes = 16;
  localparam int buf_bytes = 64;
  localparam logic [7:0] big_sector_start = 8'h80;
  localparam logic [5:0] big_sector_base = 6'h20;
  // register byte addresses
  localparam logic [7:0] adr_command = 8'h00;
  localparam logic [7:0] adr_result = 8'h04;
  localparam logic [7:0] adr_arg0 = 8'h08;
  localparam logic [7:0] adr_arg1 = 8'h0c;
  localparam logic [7:0] adr_arg2 = 8'h10;
  localparam logic [7:0] adr_irq_status = 8'h14;
  localparam logic [7:0] adr_irq_mask = 8'h18;
  localparam logic [7:0] adr_key_lo = 8'h1c;
  localparam logic [7:0] adr_key_hi = 8'h20;
  localparam logic [7:0] adr_key_store = 8'h24;
  localparam logic [7:0] adr_buf_base = 8'h40;
  // interrupt bits
  localparam int st_done_bit = 0;
  localparam int st_err_bit = 1;
  localparam logic [1:0] irq_mask_rst = 2'h0;
  // tag answer timeout
  localparam int clk_mhz = 10;
  localparam int tag_timeout_us = 10000;
  localparam int tag_timeout_cyc = tag_timeout_us * clk_mhz;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [2:0] {
    s_idle = 3'b000,
    s_auth = 3'b001,
    s_auth_w = 3'b010,
    s_write = 3'b011,
    s_write_w = 3'b100
  } cmd_state_e;
  typedef enum logic [1:0] {
    e_idle = 2'b00,
    e_req = 2'b01,
    e_rel = 2'b10
  } eng_state_e;
endpackage

// ### tag_op_if.sv
interface tag_op_if;
  logic start;
  logic op_write;
  logic [7:0] block;
  logic key_b;
  logic [47:0] key;
  logic [127:0] data;
  logic done;
  logic ok;
  modport ctl (output start, op_write, block, key_b, key, data,
               input done, ok);
  modport eng (input start, op_write, block, key_b, key, data,
               output done, ok);
endinterface

// ### tag_engine.sv
module tag_engine #(
  parameter int timeout_cyc = rfid_pkg::tag_timeout_cyc
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  tag_op_if.eng op,
  output logic tag_req,
  output logic tag_op_write,
  output logic [7:0] tag_block,
  output logic tag_key_b,
  output logic [47:0] tag_key,
  output logic [127:0] tag_data,
  input wire logic tag_ack,
  input wire logic tag_ok
);
  rfid_pkg::eng_state_e st_r;
  logic ack_m_r, ack_s_r, ok_m_r, ok_s_r;
  logic [31:0] tmo_r;
  logic done_r, res_ok_r;

  // two-stage sync of tag answer pins
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      ok_m_r <= 1'b0;
      ok_s_r <= 1'b0;
    end
    else
    begin
      ack_m_r <= tag_ack;
      ack_s_r <= ack_m_r;
      ok_m_r <= tag_ok;
      ok_s_r <= ok_m_r;
    end
  end

  // latch request payload on start
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tag_op_write <= 1'b0;
      tag_block <= 8'h00;
      tag_key_b <= 1'b0;
      tag_key <= 48'h0;
      tag_data <= 128'h0;
    end
    else if (op.start && st_r == rfid_pkg::e_idle)
    begin
      tag_op_write <= op.op_write;
      tag_block <= op.block;
      tag_key_b <= op.key_b;
      tag_key <= op.key;
      tag_data <= op.data;
    end
  end

  // four-phase handshake with answer timeout
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_r <= rfid_pkg::e_idle;
      tag_req <= 1'b0;
      tmo_r <= 32'h0;
      done_r <= 1'b0;
      res_ok_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      case (st_r)
        rfid_pkg::e_idle:
          if (op.start)
          begin
            tag_req <= 1'b1;
            tmo_r <= 32'h0;
            st_r <= rfid_pkg::e_req;
          end
        rfid_pkg::e_req:
          if (ack_s_r)
          begin
            res_ok_r <= ok_s_r;
            tag_req <= 1'b0;
            st_r <= rfid_pkg::e_rel;
          end
          else if (tmo_r == 32'(timeout_cyc - 1))
          begin
            res_ok_r <= 1'b0;
            tag_req <= 1'b0;
            st_r <= rfid_pkg::e_rel;
          end
          else
            tmo_r <= tmo_r + 32'h1;
        rfid_pkg::e_rel:
          if (!ack_s_r)
          begin
            done_r <= 1'b1;
            st_r <= rfid_pkg::e_idle;
          end
        default:
          st_r <= rfid_pkg::e_idle;
      endcase
    end
  end

  assign op.done = done_r;
  assign op.ok = res_ok_r;
endmodule

// ### rfid_write_cmd_props.sv
module rfid_write_cmd_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic tag_req,
  input wire logic tag_op_write,
  input wire logic [7:0] tag_block,
  input wire logic tag_key_b,
  input wire logic [47:0] tag_key,
  input wire logic tag_ack,
  input wire logic tag_ok
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [5:0] auth_sec_r;
  logic auth_kb_r;
  logic auth_ok_r;
  logic fail_r;
  // sector number of a block: fours below 128, sixteens above
  function automatic logic [5:0] sec(input logic [7:0] b);
    return (b < 8'h80) ? b[7:2] : (6'h20 + {3'h0, b[6:4]});
  endfunction
  // last authenticated sector, key type and outcome
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      auth_ok_r <= 1'b0;
    else if (tag_req && tag_ack && !tag_op_write)
    begin
      auth_sec_r <= sec(tag_block);
      auth_kb_r <= tag_key_b;
      auth_ok_r <= tag_ok;
    end
  end
  // a failed tag operation seen since the last request
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      fail_r <= 1'b0;
    else if ($rose(tag_req))
      fail_r <= 1'b0;
    else if (tag_req && tag_ack && !tag_ok)
      fail_r <= 1'b1;
  end
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence b_answer;
    ##2 bvalid;
  endsequence
  sequence write_up;
    $rose(tag_req) && tag_op_write;
  endsequence
  AST_WR_LAT: assert property (both_taken |-> b_answer)
    else $error("write response late");
  AST_RD_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid)
    else $error("read data dropped");
  AST_B_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("new write taken before response");
  AST_REQ_MIN: assert property ($rose(tag_req) |-> tag_req [*3])
    else $error("tag request too short");
  AST_REQ_STABLE: assert property (tag_req && $past(tag_req) |->
    $stable(tag_block) && $stable(tag_op_write) && $stable(tag_key)
    && $stable(tag_key_b)) else $error("tag request payload moved");
  AST_AUTH_FIRST: assert property (write_up |-> auth_ok_r &&
    sec(tag_block) == auth_sec_r && tag_key_b == auth_kb_r)
    else $error("block write without sector authentication");
  AST_NO_AFTER_FAIL: assert property (fail_r && $rose(tag_req)
    |-> !tag_op_write) else $error("block write after failure");
endmodule

bind rfid_write_cmd rfid_write_cmd_props u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .tag_req(tag_req), .tag_op_write(tag_op_write),
  .tag_block(tag_block), .tag_key_b(tag_key_b), .tag_key(tag_key),
  .tag_ack(tag_ack), .tag_ok(tag_ok));

// ### tag_model.sv
module tag_model (
  input wire logic core_clk,
  input wire logic tag_req,
  input wire logic tag_op_write,
  input wire logic [7:0] tag_block,
  input wire logic tag_key_b,
  input wire logic [47:0] tag_key,
  input wire logic [127:0] tag_data,
  output logic tag_ack,
  output logic tag_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  int fail_at = -1;
  int delay = 1;
  int n_ops = 0;
  logic op_w [16];
  logic [7:0] op_blk [16];
  logic op_kb [16];
  logic [47:0] op_key [16];
  logic [127:0] op_dat [16];
  // four-phase answer; ok churns while no request is up
  initial
  begin
    tag_ack = 1'b0;
    tag_ok = 1'b0;
    forever
    begin
      @(posedge core_clk);
      if (tag_req)
      begin
        repeat (delay) @(posedge core_clk);
        // a request already given up is never answered
        if (tag_req)
        begin
          op_w[n_ops] = tag_op_write;
          op_blk[n_ops] = tag_block;
          op_kb[n_ops] = tag_key_b;
          op_key[n_ops] = tag_key;
          op_dat[n_ops] = tag_data;
          tag_ok <= (n_ops != fail_at);
          tag_ack <= 1'b1;
          n_ops++;
          while (tag_req) @(posedge core_clk);
          tag_ack <= 1'b0;
        end
      end
      else
        tag_ok <= ~tag_ok;
    end
  end
endmodule

// ### tb_rfid_write_cmd.sv
module tb_rfid_write_cmd;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    bad_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
    end end
  logic core_clk = 0;
  logic sys_rst = 1;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, tag_req, tag_ack;
  logic tag_op_write, tag_key_b, tag_ok;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0] tag_block;
  logic [47:0] tag_key;
  logic [127:0] tag_data;
  int bad_count = 0;
  int num_checks = 0;
  localparam logic [47:0] key_s = 48'h5a3c96e1f00f;
  localparam logic [47:0] key_i = 48'h665544332211;

  rfid_write_cmd #(.timeout_cyc(50)) u_rfid_write_cmd (
    .core_clk(core_clk), .sys_rst(sys_rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .tag_req(tag_req),
    .tag_op_write(tag_op_write), .tag_block(tag_block),
    .tag_key_b(tag_key_b), .tag_key(tag_key), .tag_data(tag_data),
    .tag_ack(tag_ack), .tag_ok(tag_ok));
  tag_model u_tag_model (
    .core_clk(core_clk), .tag_req(tag_req), .tag_op_write(tag_op_write),
    .tag_block(tag_block), .tag_key_b(tag_key_b), .tag_key(tag_key),
    .tag_data(tag_data), .tag_ack(tag_ack), .tag_ok(tag_ok));

  initial forever #50 core_clk = ~core_clk;
  // watchdog
  initial
  begin
    #3000000;
    bad_count++;
    summarize();
  end
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd))
    begin
      @(posedge core_clk);
      if (awvalid && awready)
        ad = 1;
      if (wvalid && wready)
        wd = 1;
      if (ad)
        awvalid <= 0;
      if (wd)
        wvalid <= 0;
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 0;
    @(posedge core_clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge core_clk); while (!(arvalid && arready === 1'b1));
    arvalid <= 0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 0;
    @(posedge core_clk);
  endtask
  // load arguments, issue a code, wait for done, read the result
  task automatic run(input logic [7:0] code, input logic [7:0] blk, cnt,
    off, sel, input logic [47:0] key);
    logic [79:0] a;
    int n;
    a = {key, sel, off, cnt, blk};
    wr(rfid_pkg::adr_irq_status, 32'h3);
    wr(rfid_pkg::adr_arg0, a[31:0]);
    wr(rfid_pkg::adr_arg1, a[63:32]);
    wr(rfid_pkg::adr_arg2, {16'h0, a[79:64]});
    u_tag_model.n_ops = 0;
    wr(rfid_pkg::adr_command, {24'h0, code});
    n = 0;
    do
    begin
      rd_reg(rfid_pkg::adr_irq_status);
      n++;
    end
    while (rd[0] !== 1'b1 && n < 3000);
    `CHK(rd[0], 1'b1)
    rd_reg(rfid_pkg::adr_result);
  endtask
  task automatic chk_op(input int k, input logic w, input logic [7:0] b,
    input logic kb, input logic [47:0] key, input int off);
    logic [127:0] e;
    for (int i = 0; i < 16; i++)
      e[8*i+:8] = 8'((off + i) % 64);
    `CHK(u_tag_model.op_w[k], w)
    `CHK(u_tag_model.op_blk[k], b)
    `CHK(u_tag_model.op_kb[k], kb)
    `CHK(u_tag_model.op_key[k], key)
    if (w)
      `CHK(u_tag_model.op_dat[k], e)
  endtask

  task automatic t_reset;
    `CHK(irq, 1'b0)
    `CHK(tag_req, 1'b0)
    rd_reg(rfid_pkg::adr_result);
    `CHK(rd[7:0], rfid_pkg::res_rst)
    `CHK(resp, rfid_pkg::resp_okay)
    rd_reg(rfid_pkg::adr_irq_mask);
    `CHK(rd[1:0], rfid_pkg::irq_mask_rst)
    rd_reg(8'h30);
    `CHK(resp, rfid_pkg::resp_slverr)
    wr(8'h30, 32'h0);
    `CHK(resp, rfid_pkg::resp_slverr)
    wr(rfid_pkg::adr_irq_mask, 32'h0);
    `CHK(resp, rfid_pkg::resp_okay)
  endtask
  // stored key 39 as key B, three blocks over a sector edge
  task automatic t_stored;
    for (int i = 0; i < 16; i++)
      wr(8'(rfid_pkg::adr_buf_base + 4 * i), {8'(4*i+3), 8'(4*i+2),
        8'(4*i+1), 8'(4*i)});
    wr(rfid_pkg::adr_key_lo, key_s[31:0]);
    wr(rfid_pkg::adr_key_hi, {16'h0, key_s[47:32]});
    wr(rfid_pkg::adr_key_store, 32'd39);
    wr(rfid_pkg::adr_irq_mask, 32'h3);
    run(rfid_pkg::cmd_write_blocks, 6, 3, 16, 8'ha7, 0);
    `CHK(rd[7:0], rfid_pkg::res_no_error)
    `CHK(u_tag_model.n_ops, 5)
    chk_op(0, 0, 6, 1, key_s, 0);
    chk_op(1, 1, 6, 1, key_s, 16);
    chk_op(2, 1, 7, 1, key_s, 32);
    chk_op(3, 0, 8, 1, key_s, 0);
    chk_op(4, 1, 8, 1, key_s, 48);
    `CHK(irq, 1'b1)
    wr(rfid_pkg::adr_irq_status, 32'h1);
    `CHK(irq, 1'b0)
  endtask
  // inline key A into the large-sector area, slow tag
  task automatic t_inline;
    u_tag_model.delay = 20;
    run(rfid_pkg::cmd_write_blocks, 8'h7f, 2, 0, 8'h45, key_i);
    `CHK(rd[7:0], rfid_pkg::res_no_error)
    `CHK(u_tag_model.n_ops, 4)
    chk_op(0, 0, 8'h7f, 0, key_i, 0);
    chk_op(1, 1, 8'h7f, 0, key_i, 0);
    chk_op(2, 0, 8'h80, 0, key_i, 0);
    chk_op(3, 1, 8'h80, 0, key_i, 16);
    u_tag_model.delay = 1;
  endtask
  // failed authentication, interrupt masked then unmasked
  task automatic t_auth_fail;
    u_tag_model.fail_at = 0;
    wr(rfid_pkg::adr_irq_mask, 32'h0);
    run(rfid_pkg::cmd_write_blocks, 4, 2, 0, 8'ha7, 0);
    `CHK(rd[7:0], rfid_pkg::res_auth_err)
    `CHK(u_tag_model.n_ops, 1)
    `CHK(irq, 1'b0)
    rd_reg(rfid_pkg::adr_irq_status);
    `CHK(rd[1:0], 2'h3)
    wr(rfid_pkg::adr_irq_mask, 32'h2);
    `CHK(irq, 1'b1)
    wr(rfid_pkg::adr_irq_status, 32'h3);
    `CHK(irq, 1'b0)
    // tag too slow: answer timeout fails the stored key A authentication
    u_tag_model.fail_at = -1;
    u_tag_model.delay = 60;
    run(rfid_pkg::cmd_write_blocks, 4, 1, 0, 8'h27, 0);
    `CHK(rd[7:0], rfid_pkg::res_auth_err)
    `CHK(u_tag_model.n_ops, 0)
    u_tag_model.delay = 1;
  endtask
  task automatic t_write_fail;
    u_tag_model.fail_at = 2;
    run(rfid_pkg::cmd_write_blocks, 0, 3, 0, 8'ha7, 0);
    `CHK(rd[7:0], rfid_pkg::res_write_err)
    `CHK(u_tag_model.n_ops, 3)
    u_tag_model.fail_at = -1;
  endtask
  task automatic t_refused;
    run(8'h05, 0, 1, 0, 8'h27, 0);
    `CHK(rd[7:0], rfid_pkg::res_bad_cmd)
    `CHK(u_tag_model.n_ops, 0)
    run(rfid_pkg::cmd_write_blocks, 0, 1, 0, 8'h28, 0);
    `CHK(rd[7:0], rfid_pkg::res_key_err)
    `CHK(u_tag_model.n_ops, 0)
    rd_reg(rfid_pkg::adr_command);
    `CHK(rd[8:0], {1'b0, rfid_pkg::cmd_write_blocks})
  endtask

  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    t_reset();
    t_stored();
    t_inline();
    t_auth_fail();
    t_write_fail();
    t_refused();
    summarize();
  end
endmodule
